// ===== design/htx_pkg.sv
// Shared constants and carrier types of the HDLC transmit byte port.
// Assumes one 25 MHz system clock; the line bit rate is an enable from it.
package htx_pkg;
  localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
  localparam int unsigned LINE_DS3_HZ   = 44_736_000;
  localparam int unsigned LINE_E3_HZ    = 34_368_000;
  localparam int unsigned BITS_PER_BYTE = 8;
  // Shortest bit time (DS3) rounds down, but never below one clock cycle.
  localparam int unsigned LINE_BIT_CYC  =
    (CLK_FREQ_HZ / LINE_DS3_HZ > 0) ? CLK_FREQ_HZ / LINE_DS3_HZ : 1;
  localparam int unsigned FIFO_WORDS    = 8;

  localparam logic [7:0]  FLAG_OCTET    = 8'h7E;
  localparam logic [7:0]  ABORT_OCTET   = 8'h7F;
  localparam logic [2:0]  BYTE_LAST     = 3'h7;
  localparam logic [2:0]  STUFF_RUN     = 3'h5;
  localparam logic [5:0]  FCS16_LEN     = 6'h10;
  localparam logic [5:0]  FCS32_LEN     = 6'h20;
  localparam logic [31:0] CRC16_POLY    = 32'h0000_8408;
  localparam logic [31:0] CRC32_POLY    = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT      = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC16_MASK    = 32'h0000_FFFF;

  typedef enum logic [1:0] {
    HTX_FLAG,
    HTX_DATA,
    HTX_FCS,
    HTX_ABORT
  } htx_state_e;

  typedef struct packed {
    logic       is_check;
    logic [7:0] octet;
  } htx_entry_s;

  typedef struct packed {
    logic       send_msg;
    logic       append_check;
    logic [7:0] bus;
  } htx_pins_s;
endpackage

// ===== design/htx_transmit_byte_port.sv
// HDLC transmit byte port: demand-clocked byte intake, FIFO, framer.
// Assumes the terminal equipment changes its pins on the falling demand edge.
// Summary of operation
// - While send-message is high and append-check low, latch the byte bus at each demand rise.
// - Latched bytes enter the frame payload in arrival order.
// - While send-message is low, the byte bus is ignored.
// - With nothing to send, emit a continuous stream of 0x7E flags.
// - Append-check starts the check-value trailer of the current frame.
// - The demand clock output asks for the next byte once per demand period.
// - Demand clock runs at byte rate and slows when stuffing takes bandwidth.
// - Insert a zero after five consecutive ones inside the frame.
// - Check select high gives 32-bit check, low gives 16-bit.
// - The byte interface is active only while packet mode is enabled.

module htx_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } htx_fifo_s;

  htx_fifo_s q;
  htx_fifo_s d;
  logic      push;
  logic      pop;

  assign in_ready_out  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (q.cnt != '0);
  assign out_data_out  = q.mem[q.rp];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wp] = in_data_in;
      d.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + AW'(1);
    end
    if (pop)
    begin
      d.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + AW'(1);
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      q <= '0;
    else
      q <= d;
  end
endmodule // htx_fifo

module htx_transmit_byte_port
  import htx_pkg::*;
#(
  parameter int unsigned BIT_CYC = LINE_BIT_CYC,
  parameter int unsigned DEPTH   = FIFO_WORDS
) (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       packet_mode_en_in,
  input  wire logic       crc32_sel_in,
  input  wire logic       send_msg_cmd_in,
  input  wire logic       append_check_cmd_in,
  input  wire logic [7:0] tx_byte_bus_in,
  output logic            tx_byte_demand_clock_out,
  output logic            line_bit_out,
  output logic            line_bit_valid_out,
  output logic            frame_active_out
);
  localparam int unsigned HALF = (BITS_PER_BYTE / 2) * BIT_CYC;
  localparam int unsigned DW   = $clog2(HALF + 1);
  localparam int unsigned BW   = $clog2(BIT_CYC + 1);
  localparam int unsigned EW   = $bits(htx_entry_s);

  typedef struct packed {
    htx_pins_s     s1;
    htx_pins_s     s2;
    logic [DW-1:0] dem_cnt;
    logic          dem_clk;
    logic          prev_append;
    logic [BW-1:0] bit_cnt;
    htx_state_e    st;
    logic [7:0]    shreg;
    logic [2:0]    bit_idx;
    logic [5:0]    fcs_left;
    logic [2:0]    ones;
    logic [31:0]   crc;
    logic          crc32;
    logic          bit_q;
    logic          valid_q;
    logic          active_q;
  } htx_top_s;

  localparam htx_top_s RST = '{
    s1: '0, s2: '0, dem_cnt: '0, dem_clk: 1'b0, prev_append: 1'b0,
    bit_cnt: '0, st: HTX_FLAG, shreg: FLAG_OCTET, bit_idx: '0,
    fcs_left: '0, ones: '0, crc: CRC_INIT, crc32: 1'b0,
    bit_q: 1'b0, valid_q: 1'b0, active_q: 1'b0};

  htx_top_s   q;
  htx_top_s   d;
  logic       rise;
  logic       push_valid;
  htx_entry_s push_entry;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  htx_entry_s fifo_out;
  logic       pop;
  logic       line_en;
  logic       stuff;
  logic       tx_bit;
  logic       unit_end;
  logic [31:0] crc_nx;
  logic [31:0] poly;

  assign tx_byte_demand_clock_out = q.dem_clk;
  assign line_bit_out             = q.bit_q;
  assign line_bit_valid_out       = q.valid_q;
  assign frame_active_out         = q.active_q;

  // A rise is only made when the FIFO can take the byte, so back-pressure
  // from stuffing stretches the low phase instead of dropping data.
  assign rise = (q.dem_cnt == DW'(HALF-1)) && !q.dem_clk
                && packet_mode_en_in && fifo_in_ready;
  assign line_en = (q.bit_cnt == BW'(BIT_CYC-1));
  // A run of ones left by the last check bit must be broken in the flag state
  // too, or the far end strips the first flag bit as a stuffed zero.
  assign stuff = (q.ones == STUFF_RUN);
  assign tx_bit = (q.st == HTX_FCS) ? q.crc[0] : q.shreg[0];
  assign unit_end = (q.st == HTX_FCS) ? (q.fcs_left == 6'h01)
                                      : (q.bit_idx == BYTE_LAST);
  assign poly = q.crc32 ? CRC32_POLY : CRC16_POLY;

  always_comb
  begin
    push_valid = 1'b0;
    push_entry = '0;
    if (rise)
    begin
      // The synced bus is two cycles old; the far end changed it at the
      // falling edge half a period earlier, so it has settled by now.
      if (q.s2.append_check)
      begin
        // Later periods of a two- or four-period hold carry no new token.
        push_valid = !q.prev_append;
        push_entry.is_check = 1'b1;
      end
      else if (q.s2.send_msg)
      begin
        push_valid = 1'b1;
        push_entry.octet = q.s2.bus;
      end
    end
  end

  htx_fifo #(
    .WIDTH (EW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (push_valid),
    .in_data_in    (push_entry),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out),
    .out_ready_in  (pop)
  );

  always_comb
  begin
    d = q;
    pop = 1'b0;
    crc_nx = q.crc;
    d.s1 = '{send_msg: send_msg_cmd_in, append_check: append_check_cmd_in,
             bus: tx_byte_bus_in};
    d.s2 = q.s1;

    // Demand clock divider, one phase per HALF cycles.
    if (q.dem_cnt != DW'(HALF-1))
      d.dem_cnt = q.dem_cnt + DW'(1);
    else if (q.dem_clk)
    begin
      d.dem_cnt = '0;
      d.dem_clk = 1'b0;
    end
    else if (rise)
    begin
      d.dem_cnt = '0;
      d.dem_clk = 1'b1;
      d.prev_append = q.s2.append_check;
    end

    d.valid_q = line_en;
    d.bit_cnt = line_en ? '0 : q.bit_cnt + BW'(1);
    if (line_en)
    begin
      if (stuff)
      begin
        d.bit_q = 1'b0;
        d.ones = '0;
      end
      else
      begin
        d.bit_q = tx_bit;
        if (q.st == HTX_DATA || q.st == HTX_FCS)
          d.ones = tx_bit ? q.ones + 3'h1 : '0;
        else
          d.ones = '0;
        if (q.st == HTX_DATA)
        begin
          crc_nx = (q.crc >> 1) ^ (((q.crc[0] ^ tx_bit)) ? poly : '0);
          d.crc = crc_nx;
        end
        if (q.st == HTX_FCS)
        begin
          d.crc = q.crc >> 1;
          d.fcs_left = q.fcs_left - 6'h01;
        end
        d.shreg = q.shreg >> 1;
        d.bit_idx = q.bit_idx + 3'h1;
        if (unit_end)
        begin
          d.bit_idx = '0;
          d.shreg = FLAG_OCTET;
          d.st = HTX_FLAG;
          case (q.st)
            HTX_FLAG:
            begin
              if (fifo_out_valid)
              begin
                pop = 1'b1;
                // A check token outside a frame is stray and dropped.
                if (!fifo_out.is_check)
                begin
                  d.st = HTX_DATA;
                  d.shreg = fifo_out.octet;
                  d.crc = crc32_sel_in ? CRC_INIT : (CRC_INIT & CRC16_MASK);
                  d.crc32 = crc32_sel_in;
                end
              end
            end
            HTX_DATA:
            begin
              if (fifo_out_valid && !fifo_out.is_check)
              begin
                pop = 1'b1;
                d.st = HTX_DATA;
                d.shreg = fifo_out.octet;
              end
              else if (fifo_out_valid)
              begin
                pop = 1'b1;
                d.st = HTX_FCS;
                d.crc = ~crc_nx & (q.crc32 ? CRC_INIT : CRC16_MASK);
                d.fcs_left = q.crc32 ? FCS32_LEN : FCS16_LEN;
              end
              else
              begin
                // Underrun mid-frame: the frame cannot be saved, so abort it.
                d.st = HTX_ABORT;
                d.shreg = ABORT_OCTET;
              end
            end
            HTX_FCS: d.st = HTX_FLAG;
            HTX_ABORT: d.st = HTX_FLAG;
            default: d.st = HTX_FLAG;
          endcase
        end
      end
    end
    d.active_q = (d.st != HTX_FLAG);
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      q <= RST;
    else
      q <= d;
  end

  sample_on_rise_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    rise && q.s2.send_msg && !q.s2.append_check
    |-> push_valid && !push_entry.is_check && push_entry.octet == q.s2.bus)
    else $error("Byte not latched at demand rise.");

  ignore_bus_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !q.s2.send_msg && !q.s2.append_check |-> !push_valid)
    else $error("Byte latched while send-message low.");

  idle_flag_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    line_en && q.st == HTX_FLAG
    |=> line_bit_out == FLAG_OCTET[$past(q.bit_idx)] && line_bit_valid_out)
    else $error("Idle bit is not a flag bit.");

  check_token_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    rise && q.s2.append_check |-> push_valid == !q.prev_append
      && (!push_valid || push_entry.is_check))
    else $error("Check token push wrong.");

  demand_high_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    $rose(tx_byte_demand_clock_out) |-> tx_byte_demand_clock_out [*4] ##1
      !tx_byte_demand_clock_out)
    else $error("Demand clock high phase wrong.");

  stall_full_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !fifo_in_ready |=> !$rose(tx_byte_demand_clock_out))
    else $error("Demand rise while buffer full.");

  disabled_quiet_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !packet_mode_en_in |=> !$rose(tx_byte_demand_clock_out))
    else $error("Demand rise while packet mode off.");

  stuff_zero_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    line_en && stuff |=> !line_bit_out && q.ones == 3'h0)
    else $error("Missing stuffed zero.");

  check_len_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    q.st == HTX_FCS && $past(q.st) == HTX_DATA
    |-> q.fcs_left == (q.crc32 ? FCS32_LEN : FCS16_LEN))
    else $error("Check length does not follow select.");

  closing_flag_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    q.st == HTX_FLAG && $past(q.st) == HTX_FCS
    |-> q.shreg == FLAG_OCTET && q.bit_idx == 3'h0)
    else $error("No closing flag after check.");
endmodule // htx_transmit_byte_port

// ===== verification/htx_term_model.sv
// Terminal equipment model that feeds the byte port one item per demand period.
// Assumes it shares ref_clk_in with the port and watches the demand clock output.
module htx_term_model (
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       demand_in,
  output logic            send_out,
  output logic            append_out,
  output logic [7:0]      bus_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] item_q[$];
  logic       dem_q = 1'b0;

  // Check requests are queued behind the last byte, so they never overtake it.
  task automatic queue_frame(input logic [7:0] d[$], input logic is32, input int gap);
    for (int i = 0; i < gap; i++) item_q.push_back(10'h000);
    foreach (d[i]) item_q.push_back({2'b10, d[i]});
    for (int i = 0; i < (is32 ? 4 : 2); i++) item_q.push_back(10'h100);
  endtask

  always @(posedge ref_clk_in)
  begin
    dem_q <= demand_in;
    if (sys_rst_in)
    begin
      send_out <= 1'b0;
      append_out <= 1'b0;
      bus_out <= 8'h00;
    end
    else if (dem_q && !demand_in)
    begin
      if (item_q.size() != 0)
        {send_out, append_out, bus_out} <= item_q.pop_front();
      else
      begin
        {send_out, append_out} <= 2'b00;
        bus_out <= ~bus_out;
      end
    end
    // An unused bus keeps moving, so a stale byte can never pass for fresh data.
    else if (!send_out)
      bus_out <= ~bus_out;
  end
endmodule // htx_term_model

// ===== verification/tb_top.sv
// Self-checking bench of the HDLC transmit byte port and of its FIFO.
// Assumes one 25 MHz clock; the line stream is decoded here, flags and stuffing alike.
module tb_top
  import htx_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic       ref_clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       mode_en = 1'b1;
  logic       crc32_sel = 1'b0;
  logic       send, append, demand, lbit, lvalid, active;
  logic [7:0] bus, raw, b;
  logic [7:0] rx_bytes[$];
  int         rx_lens[$];
  logic       bits[$];
  int         ones, flags, hi, lo, lo_max, bad_count, samples_checked;

  always #20 ref_clk_in = ~ref_clk_in;

  htx_transmit_byte_port #(.BIT_CYC(1), .DEPTH(8)) htx_transmit_byte_port_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .packet_mode_en_in(mode_en),
    .crc32_sel_in(crc32_sel), .send_msg_cmd_in(send), .append_check_cmd_in(append),
    .tx_byte_bus_in(bus), .tx_byte_demand_clock_out(demand), .line_bit_out(lbit),
    .line_bit_valid_out(lvalid), .frame_active_out(active));

  htx_term_model htx_term_model_inst (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .demand_in(demand),
    .send_out(send), .append_out(append), .bus_out(bus));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] fcs_of(input logic [7:0] d[$], input logic is32);
    logic [31:0] c;
    c = is32 ? CRC_INIT : CRC_INIT & CRC16_MASK;
    foreach (d[i]) for (int k = 0; k < 8; k++)
      c = (c[0] ^ d[i][k]) ? (c >> 1) ^ (is32 ? CRC32_POLY : CRC16_POLY) : c >> 1;
    return is32 ? ~c : ~c & CRC16_MASK;
  endfunction

  // Sampled on the falling edge, where every registered output has settled.
  always @(negedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      hi = 0;
      lo = 0;
    end
    else if (demand)
    begin
      if (hi == 0 && lo != 0)
      begin
        check("demand_low", lo >= 4, 1);
        lo_max = (lo > lo_max) ? lo : lo_max;
      end
      lo = 0;
      hi++;
    end
    else if (hi != 0)
    begin
      check("demand_high", hi, 4);
      hi = 0;
      lo = 1;
    end
    else if (lo != 0)
      lo++;
    if (!sys_rst_in && lvalid)
    begin
      raw = {lbit, raw[7:1]};
      if (ones == 5 && !lbit)
        ones = 0;
      else
      begin
        bits.push_back(lbit);
        ones = lbit ? ones + 1 : 0;
      end
      if (raw == FLAG_OCTET)
      begin
        flags++;
        if (bits.size() > 8 && bits.size() % 8 == 0)
        begin
          for (int i = 0; i < bits.size() - 8; i += 8)
          begin
            for (int k = 0; k < 8; k++) b[k] = bits[i + k];
            rx_bytes.push_back(b);
          end
          rx_lens.push_back(bits.size() / 8 - 1);
        end
        bits.delete();
        ones = 0;
      end
    end
  end

  task automatic test_idle();
    flags = 0;
    repeat (200) @(negedge ref_clk_in);
    check("idle_flags", flags > 20, 1);
    check("idle_frames", rx_lens.size(), 0);
    check("idle_active", active, 1'b0);
  endtask

  task automatic run_frames(input logic [7:0] d[$], input logic is32, input int gap,
                            input int reps);
    logic [7:0]  got[$];
    logic [31:0] fcs;
    int          n, len;
    n = d.size() + (is32 ? 4 : 2);
    fcs = fcs_of(d, is32);
    rx_lens.delete();
    rx_bytes.delete();
    @(posedge ref_clk_in) crc32_sel <= is32;
    for (int r = 0; r < reps; r++) htx_term_model_inst.queue_frame(d, is32, r == 0 ? gap : 0);
    for (int t = 0; t < 4000 && rx_lens.size() < reps; t++) @(posedge ref_clk_in);
    check("frames", rx_lens.size(), reps);
    while (rx_lens.size() != 0)
    begin
      got.delete();
      len = rx_lens.pop_front();
      check("frame_len", len, n);
      for (int i = 0; i < len; i++) got.push_back(rx_bytes.pop_front());
      if (len == n)
      begin
        foreach (d[i]) check("payload", got[i], d[i]);
        for (int k = 0; k < n - d.size(); k++) check("fcs", got[d.size() + k], fcs[8*k +: 8]);
      end
    end
  endtask

  task automatic test_disable();
    int seen;
    seen = 0;
    @(posedge ref_clk_in) mode_en <= 1'b0;
    repeat (12) @(posedge ref_clk_in);
    repeat (100) @(negedge ref_clk_in) seen += (demand !== 1'b0);
    check("demand_off", seen, 0);
    @(posedge ref_clk_in) mode_en <= 1'b1;
  endtask

  // A long run of ones is stuffed, so the line falls behind the demand clock
  // until the buffer fills; the low phase must stretch and no byte may be lost.
  task automatic test_fifo();
    logic [7:0] d[$];
    for (int i = 0; i < 60; i++) d.push_back(8'hFF);
    lo_max = 0;
    run_frames(d, 1'b0, 0, 1);
    @(negedge ref_clk_in);
    check("fifo_full_stall", lo_max > 4, 1);
    check("fifo_empty", active, 1'b0);
    lo_max = 0;
    repeat (100) @(negedge ref_clk_in);
    check("fifo_ready", lo_max, 4);
  endtask

  initial
  begin
    repeat (4) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    test_idle();
    run_frames({8'h11, 8'h22, 8'h33}, 1'b0, 0, 1);
    run_frames({8'hFF, 8'hFF, 8'h7E, 8'h7F, 8'h00, 8'hFF}, 1'b1, 3, 2);
    test_disable();
    run_frames({8'h5A}, 1'b0, 0, 1);
    test_fifo();
    finish_test();
  end

  // The whole sequence needs under two thousand cycles; this margin catches a hang.
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    bad_count++;
    finish_test();
  end
endmodule // tb_top
